// ==== design/bcc_top.sv ====
// Control logic for six low-voltage buck channels with an AHB-Lite slave.
// Assumes all inputs are synchronous to CLOCK and the OTP inputs are static.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - Ramp only within 0.4-1.5 V; crossing to/from 1.8 V turns channel off, on.
// - Power-up loads autoskip for sequenced channels, off for the rest.
// - Separate run and standby two-bit modes; current state's field governs.
// - Any channel mode change sets sticky flag, drives low interrupt unless masked.
// - Two-bit current limit field per channel selects peak current threshold.
// - Three-bit phase field: 000 is 45 degrees, steps of 45, 111 zero.
// - Phase field defaults to zero degrees at power-up, stays writable.
// - Two-bit inductor field per channel: 1.0, 0.47, 1.5 uH, 11 reserved.
// - Termination enabled: channel 6 tracks half channel 5, no ramping while tracking.
// - Same slot: channel 6 tracks at once; later slot: ramp first, then track.
// - Channel 5 disabled: channel 6 keeps tracking, both pulled down.
// - Channel 6 alone off: OTP bit picks high impedance or pull-down.
// - Channel 6 re-enabled alone ramps to set point, then tracks again.
// - Grouping 1-4: single, dual 1-2, quad 1-4, triple 1-3.
// - Grouped channels use their leader's registers; phase stays per channel.
// - In triple phase channel 4 stays an independent single channel.
// - Grouping 3-4: 00 single, 01 dual led by channel 4; rest reserved.
// - Triple or quad grouping overrides the channels 3-4 grouping field.
// - Grouping 5-6: 00 single, 01 dual led by channel 5; rest reserved.
// - Voltage code 0-176 is 0.4 V up, 177 is 1.8 V, above reserved.
module bcc_top #(
   parameter int OFF_CYCLES = bcc_pkg::AUTO_OFF_CYC
) (
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        POWER_UP,
   input  wire logic        STANDBY,
   input  wire logic [5:0]  SEQ_EN,
   input  wire logic        SAME_SLOT,
   input  wire logic        CH6_AT_TARGET,
   input  wire logic [47:0] OTP_VOLTAGE_CODE,
   input  wire logic [11:0] INDUCTOR_VALUE_SEL,
   input  wire logic [1:0]  CH1_TO_4_GROUPING,
   input  wire logic [1:0]  CH3_4_GROUPING,
   input  wire logic [1:0]  CH5_6_GROUPING,
   input  wire logic        TERMINATION_OFF_PULLDOWN,
   input  wire logic [7:0]  CH6_BOOT_SETPOINT,
   output wire logic [5:0]  CH_ENABLE,
   output wire logic [11:0] CH_MODE,
   output wire logic [47:0] CH_VOLTAGE_CODE,
   output wire logic [11:0] CURRENT_LIMIT_SEL,
   output wire logic [17:0] PHASE_SHIFT_SEL,
   output wire logic [11:0] INDUCTOR_OUT,
   output wire logic [5:0]  CH_DVS_EN,
   output wire logic [5:0]  CH_PULLDOWN,
   output wire logic [17:0] CH_LEADER,
   output logic             TRACK_CH5,
   output logic             IRQ_OUT_N
);
   import bcc_pkg::*;

   logic [31:0]        addr_ff,   nxt_addr;
   logic               wr_ff,     nxt_wr;
   logic [31:0]        rdata_ff,  nxt_rdata;
   logic               term_ff,   nxt_term;
   logic               mask_ff,   nxt_mask;
   logic [5:0]         evt_ff,    nxt_evt;
   logic               irq_n_ff,  nxt_irq_n;
   logic               trk_ff,    nxt_trk;
   bcc_term_state_type tst_ff,    nxt_tst;
   logic [5:0][1:0]    runm_ff,   nxt_runm;
   logic [5:0][1:0]    stbm_ff,   nxt_stbm;
   logic [5:0][1:0]    ilim_ff,   nxt_ilim;
   logic [5:0][2:0]    phase_ff,  nxt_phase;
   logic [5:0][7:0]    runv_ff,   nxt_runv;
   logic [5:0][7:0]    stbv_ff,   nxt_stbv;
   wire  [5:0][1:0]    cur_mode;
   wire  [5:0]         mode_evt;

   assign HRDATA    = rdata_ff;
   assign HREADYOUT = 1'h1;
   assign HRESP     = 1'h0;
   assign TRACK_CH5 = trk_ff;
   assign IRQ_OUT_N = irq_n_ff;

   // Picks the channel whose registers steer channel ch. The grouping
   // fields come in as arguments, so that every caller sees their changes.
   function automatic logic [2:0] lead_of(input int         ch,
                                          input logic [1:0] g14,
                                          input logic [1:0] g34,
                                          input logic [1:0] g56);
      logic [2:0] l;
      l = 3'(ch);
      unique case (ch)
         1: begin
            if (g14 != GRP14_SINGLE) begin
               l = 3'h0;
            end
         end
         2: begin
            if (g14 == GRP14_QUAD || g14 == GRP14_TRIPLE) begin
               l = 3'h0;
            end else if (g34 == GRP_DUAL) begin
               l = 3'h3;
            end
         end
         3: begin
            if (g14 == GRP14_QUAD) begin
               l = 3'h0;
            end
         end
         5: begin
            if (g56 == GRP_DUAL) begin
               l = 3'h4;
            end
         end
         default: l = 3'(ch);
      endcase
      return l;
   endfunction

   function automatic logic [31:0] read_word(input logic [31:0] a);
      logic [31:0] w;
      int          c;
      w = 32'h0000_0000;
      c = int'((a - REG_CH_BASE) / REG_STRIDE);
      if (a == REG_CTRL) begin
         w[CTRL_TERM_BIT] = term_ff;
         w[CTRL_MASK_BIT] = mask_ff;
      end else if (a == REG_STATUS) begin
         w[5:0]                 = evt_ff;
         w[STAT_EN_LSB +: 6]    = CH_ENABLE;
         w[STAT_TRK_BIT]        = trk_ff;
      end else if (a >= REG_CH_BASE && a < REG_CH_END &&
                   a[1:0] == 2'h0) begin
         w[CH_RUNM_LSB +: 2]  = runm_ff[c];
         w[CH_STBM_LSB +: 2]  = stbm_ff[c];
         w[CH_ILIM_LSB +: 2]  = ilim_ff[c];
         w[CH_PHASE_LSB +: 3] = phase_ff[c];
         w[CH_RUNV_LSB +: 8]  = runv_ff[c];
         w[CH_STBV_LSB +: 8]  = stbv_ff[c];
      end
      return w;
   endfunction

   always_comb begin
      int c;
      c         = int'((addr_ff - REG_CH_BASE) / REG_STRIDE);
      nxt_addr  = addr_ff;
      nxt_wr    = 1'h0;
      nxt_rdata = 32'h0000_0000;
      nxt_term  = term_ff;
      nxt_mask  = mask_ff;
      nxt_evt   = evt_ff;
      nxt_runm  = runm_ff;
      nxt_stbm  = stbm_ff;
      nxt_ilim  = ilim_ff;
      nxt_phase = phase_ff;
      nxt_runv  = runv_ff;
      nxt_stbv  = stbv_ff;
      nxt_tst   = tst_ff;
      if (HSEL && HREADY && HTRANS[HTRANS_ACT_BIT]) begin
         nxt_addr  = HADDR;
         nxt_wr    = HWRITE;
         nxt_rdata = HWRITE ? 32'h0000_0000 : read_word(HADDR);
      end
      if (wr_ff) begin
         if (addr_ff == REG_CTRL) begin
            nxt_term = HWDATA[CTRL_TERM_BIT];
            nxt_mask = HWDATA[CTRL_MASK_BIT];
         end else if (addr_ff == REG_STATUS) begin
            nxt_evt = evt_ff & ~HWDATA[5:0];
         end else if (addr_ff >= REG_CH_BASE && addr_ff < REG_CH_END &&
                      addr_ff[1:0] == 2'h0) begin
            nxt_runm[c]  = HWDATA[CH_RUNM_LSB +: 2];
            nxt_stbm[c]  = HWDATA[CH_STBM_LSB +: 2];
            nxt_ilim[c]  = HWDATA[CH_ILIM_LSB +: 2];
            nxt_phase[c] = HWDATA[CH_PHASE_LSB +: 3];
            nxt_runv[c]  = HWDATA[CH_RUNV_LSB +: 8];
            nxt_stbv[c]  = HWDATA[CH_STBV_LSB +: 8];
         end
      end
      if (POWER_UP) begin
         for (int i = 0; i < NCH; i++) begin
            nxt_runm[i]  = SEQ_EN[i] ? MODE_AUTO : MODE_OFF;
            nxt_stbm[i]  = SEQ_EN[i] ? MODE_AUTO : MODE_OFF;
            nxt_phase[i] = PHASE_0DEG;
            nxt_ilim[i]  = ILIM_2A1;
            nxt_runv[i]  = OTP_VOLTAGE_CODE[i*8 +: 8];
            nxt_stbv[i]  = OTP_VOLTAGE_CODE[i*8 +: 8];
         end
      end
      // A mode change in the clearing cycle still sets its flag.
      nxt_evt   = nxt_evt | mode_evt;
      nxt_irq_n = ~((|nxt_evt) & ~nxt_mask);
      if (POWER_UP) begin
         if (!SEQ_EN[NCH-1]) begin
            nxt_tst = TS_OFF;
         end else begin
            nxt_tst = SAME_SLOT ? TS_TRACK : TS_BOOT_RAMP;
         end
      end else if (cur_mode[NCH-1] == MODE_OFF) begin
         nxt_tst = TS_OFF;
      end else begin
         unique case (tst_ff)
            TS_OFF:       nxt_tst = TS_RAMP;
            TS_BOOT_RAMP,
            TS_RAMP: begin
               if (CH6_AT_TARGET) begin
                  nxt_tst = TS_TRACK;
               end
            end
            TS_TRACK:     nxt_tst = TS_TRACK;
         endcase
      end
      nxt_trk = nxt_term && nxt_tst == TS_TRACK;
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         addr_ff  <= 32'h0000_0000;
         wr_ff    <= 1'h0;
         rdata_ff <= 32'h0000_0000;
         term_ff  <= 1'h0;
         mask_ff  <= 1'h0;
         evt_ff   <= 6'h00;
         irq_n_ff <= 1'h1;
         trk_ff   <= 1'h0;
         tst_ff   <= TS_OFF;
         runm_ff  <= '0;
         stbm_ff  <= '0;
         ilim_ff  <= '0;
         phase_ff <= {NCH{PHASE_0DEG}};
         runv_ff  <= '0;
         stbv_ff  <= '0;
      end else begin
         addr_ff  <= nxt_addr;
         wr_ff    <= nxt_wr;
         rdata_ff <= nxt_rdata;
         term_ff  <= nxt_term;
         mask_ff  <= nxt_mask;
         evt_ff   <= nxt_evt;
         irq_n_ff <= nxt_irq_n;
         trk_ff   <= nxt_trk;
         tst_ff   <= nxt_tst;
         runm_ff  <= nxt_runm;
         stbm_ff  <= nxt_stbm;
         ilim_ff  <= nxt_ilim;
         phase_ff <= nxt_phase;
         runv_ff  <= nxt_runv;
         stbv_ff  <= nxt_stbv;
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      logic [2:0]       ld;
      logic [1:0]       m;
      logic [7:0]       tgt;
      logic             is_vtt;
      logic [7:0]       app_ff,  nxt_app;
      logic [CNT_W-1:0] cnt_ff,  nxt_cnt;
      logic             en_ff,   nxt_en;
      logic [1:0]       mode_ff, nxt_mode;
      logic             dvs_ff,  nxt_dvs;
      logic             pd_ff,   nxt_pd;
      logic [2:0]       ld_ff,   nxt_ld;
      logic [1:0]       il_ff,   nxt_il;
      logic [2:0]       ph_ff,   nxt_ph;
      logic [1:0]       ind_ff,  nxt_ind;

      assign ld       = lead_of(g, CH1_TO_4_GROUPING, CH3_4_GROUPING,
                                CH5_6_GROUPING);
      assign m        = STANDBY ? stbm_ff[ld] : runm_ff[ld];
      assign is_vtt   = (g == NCH - 1) && term_ff;
      assign cur_mode[g] = m;
      assign mode_evt[g] = m != mode_ff;

      assign CH_ENABLE[g]               = en_ff;
      assign CH_MODE[g*2 +: 2]          = mode_ff;
      assign CH_VOLTAGE_CODE[g*8 +: 8]  = app_ff;
      assign CURRENT_LIMIT_SEL[g*2 +: 2] = il_ff;
      assign PHASE_SHIFT_SEL[g*3 +: 3]  = ph_ff;
      assign INDUCTOR_OUT[g*2 +: 2]     = ind_ff;
      assign CH_DVS_EN[g]               = dvs_ff;
      assign CH_PULLDOWN[g]             = pd_ff;
      assign CH_LEADER[g*3 +: 3]        = ld_ff;

      always_comb begin
         tgt = STANDBY ? stbv_ff[ld] : runv_ff[ld];
         if (is_vtt && tst_ff == TS_BOOT_RAMP) begin
            tgt = CH6_BOOT_SETPOINT;
         end
         nxt_app = app_ff;
         nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
         // Codes above the 1.8 V code are ignored and the old one kept.
         if (tgt <= VCODE_HIGH && tgt != app_ff && !(is_vtt && trk_ff)) begin
            nxt_app = tgt;
            if ((tgt <= VCODE_LOW_MAX) != (app_ff <= VCODE_LOW_MAX)) begin
               nxt_cnt = CNT_W'(OFF_CYCLES);
            end
         end
         nxt_mode = m;
         nxt_en   = m != MODE_OFF && nxt_cnt == '0;
         // The next tracking state is used, so that ramping stops on the
         // very edge at which tracking starts.
         nxt_dvs  = nxt_en && !((g == NCH - 1) && nxt_trk);
         nxt_pd   = !nxt_en;
         if (is_vtt && !nxt_en) begin
            nxt_pd = TERMINATION_OFF_PULLDOWN;
         end
         if (is_vtt && trk_ff && cur_mode[NCH-2] == MODE_OFF) begin
            nxt_pd = 1'h1;
         end
         nxt_il  = ilim_ff[ld];
         nxt_ld  = ld;
         nxt_ph  = phase_ff[g];
         nxt_ind = INDUCTOR_VALUE_SEL[g*2 +: 2];
         if (nxt_ind == IND_RSVD) begin
            nxt_ind = IND_1U0;
         end
      end

      always_ff @(posedge CLOCK) begin
         if (RESET) begin
            app_ff  <= 8'h00;
            cnt_ff  <= '0;
            en_ff   <= 1'h0;
            mode_ff <= MODE_OFF;
            dvs_ff  <= 1'h0;
            pd_ff   <= 1'h1;
            ld_ff   <= 3'(g);
            il_ff   <= ILIM_2A1;
            ph_ff   <= PHASE_0DEG;
            ind_ff  <= IND_1U0;
         end else begin
            app_ff  <= nxt_app;
            cnt_ff  <= nxt_cnt;
            en_ff   <= nxt_en;
            mode_ff <= nxt_mode;
            dvs_ff  <= nxt_dvs;
            pd_ff   <= nxt_pd;
            ld_ff   <= nxt_ld;
            il_ff   <= nxt_il;
            ph_ff   <= nxt_ph;
            ind_ff  <= nxt_ind;
         end
      end
   end
endmodule

// ==== design/bcc_pkg.sv ====
// Constants, register map and types for the buck channel control block.
// Assumes a 100 MHz system clock and an AHB-Lite register bus.
package bcc_pkg;
   localparam int NCH          = 6;
   localparam int CLK_FREQ_MHZ = 100;
   localparam int AUTO_OFF_NS  = 1000;
   localparam int AUTO_OFF_CYC = (AUTO_OFF_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int CNT_W        = 16;

   localparam logic [1:0] MODE_OFF  = 2'h0;
   localparam logic [1:0] MODE_PWM  = 2'h1;
   localparam logic [1:0] MODE_PFM  = 2'h2;
   localparam logic [1:0] MODE_AUTO = 2'h3;

   localparam logic [1:0] ILIM_2A1  = 2'h0;
   localparam logic [2:0] PHASE_0DEG = 3'h7;
   localparam logic [1:0] IND_1U0   = 2'h0;
   localparam logic [1:0] IND_RSVD  = 2'h3;

   localparam logic [1:0] GRP14_SINGLE = 2'h0;
   localparam logic [1:0] GRP14_QUAD   = 2'h2;
   localparam logic [1:0] GRP14_TRIPLE = 2'h3;
   localparam logic [1:0] GRP_DUAL     = 2'h1;

   localparam logic [7:0] VCODE_LOW_MAX = 8'hB0;
   localparam logic [7:0] VCODE_HIGH    = 8'hB1;

   localparam logic [31:0] REG_CTRL    = 32'h0000_0000;
   localparam logic [31:0] REG_STATUS  = 32'h0000_0004;
   localparam logic [31:0] REG_CH_BASE = 32'h0000_0010;
   localparam logic [31:0] REG_STRIDE  = 32'h0000_0004;
   localparam logic [31:0] REG_CH_END  = 32'h0000_0028;

   localparam int CTRL_TERM_BIT = 0;
   localparam int CTRL_MASK_BIT = 1;
   localparam int CH_RUNM_LSB   = 0;
   localparam int CH_STBM_LSB   = 2;
   localparam int CH_ILIM_LSB   = 4;
   localparam int CH_PHASE_LSB  = 6;
   localparam int CH_RUNV_LSB   = 16;
   localparam int CH_STBV_LSB   = 24;
   localparam int STAT_EN_LSB   = 8;
   localparam int STAT_TRK_BIT  = 16;
   localparam int HTRANS_ACT_BIT = 1;

   typedef enum logic [1:0] {
      TS_OFF,
      TS_BOOT_RAMP,
      TS_RAMP,
      TS_TRACK
   } bcc_term_state_type;
endpackage

// ==== bench/bcc_properties.sv ====
// Concurrent checks on the buck channel control ports.
// Assumes grouping and inductor inputs change only between tests.
`timescale 1ns/100ps
module bcc_properties #(
   parameter int OFF_CYCLES = 3
) (
   input logic        CLOCK,
   input logic        RESET,
   input logic        HSEL,
   input logic [1:0]  HTRANS,
   input logic        HWRITE,
   input logic        HREADY,
   input logic [31:0] HRDATA,
   input logic        HREADYOUT,
   input logic        HRESP,
   input logic        POWER_UP,
   input logic [11:0] INDUCTOR_VALUE_SEL,
   input logic [1:0]  CH1_TO_4_GROUPING,
   input logic [1:0]  CH3_4_GROUPING,
   input logic [1:0]  CH5_6_GROUPING,
   input logic [11:0] INDUCTOR_OUT,
   input logic [17:0] PHASE_SHIFT_SEL,
   input logic [5:0]  CH_DVS_EN,
   input logic [17:0] CH_LEADER,
   input logic        TRACK_CH5,
   input logic        IRQ_OUT_N
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   chk_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not ready and okay");
   chk_rdata_idle: assert property (HRDATA != 32'h0 |->
      $past(HSEL && HTRANS[1] && !HWRITE && HREADY))
      else $error("read data outside a read");
   chk_phase_boot: assert property (POWER_UP |-> ##2 &PHASE_SHIFT_SEL)
      else $error("phase not zero degrees after power up");
   chk_leader_two: assert property (!$past(RESET) |-> CH_LEADER[5:3] ==
      (($past(CH1_TO_4_GROUPING) != 2'h0) ? 3'h0 : 3'h1))
      else $error("channel 2 leader wrong");
   chk_leader_three: assert property (!$past(RESET) |-> CH_LEADER[8:6] ==
      ($past(CH1_TO_4_GROUPING[1]) ? 3'h0 :
      (($past(CH3_4_GROUPING) == 2'h1) ? 3'h3 : 3'h2)))
      else $error("channel 3 leader wrong");
   chk_leader_four: assert property (!$past(RESET) |-> CH_LEADER[11:9] ==
      (($past(CH1_TO_4_GROUPING) == 2'h2) ? 3'h0 : 3'h3))
      else $error("channel 4 leader wrong");
   chk_leader_six: assert property (!$past(RESET) |-> CH_LEADER[17:15] ==
      (($past(CH5_6_GROUPING) == 2'h1) ? 3'h4 : 3'h5))
      else $error("channel 6 leader wrong");
   chk_inductor_map: assert property (!$past(RESET) |-> INDUCTOR_OUT[1:0] ==
      (&$past(INDUCTOR_VALUE_SEL[1:0]) ? 2'h0 : $past(INDUCTOR_VALUE_SEL[1:0])))
      else $error("inductor code not mapped");
   chk_track_dvs: assert property (TRACK_CH5 |-> !CH_DVS_EN[5])
      else $error("ramping while tracking");
   cover property (POWER_UP);
   cover property (!IRQ_OUT_N);
   cover property (TRACK_CH5);
endmodule

bind bcc_top bcc_properties #(.OFF_CYCLES(OFF_CYCLES)) i_chk (
   .CLOCK(CLOCK), .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .POWER_UP(POWER_UP),
   .INDUCTOR_VALUE_SEL(INDUCTOR_VALUE_SEL),
   .CH1_TO_4_GROUPING(CH1_TO_4_GROUPING), .CH3_4_GROUPING(CH3_4_GROUPING),
   .CH5_6_GROUPING(CH5_6_GROUPING), .INDUCTOR_OUT(INDUCTOR_OUT),
   .PHASE_SHIFT_SEL(PHASE_SHIFT_SEL), .CH_DVS_EN(CH_DVS_EN),
   .CH_LEADER(CH_LEADER), .TRACK_CH5(TRACK_CH5), .IRQ_OUT_N(IRQ_OUT_N));

// ==== bench/tb.sv ====
// Self-checking bench for the buck channel control block.
// Assumes a zero-wait AHB-Lite slave and a short auto-off count.
`timescale 1ns/100ps
module tb;
   import bcc_pkg::*;
   localparam int OFFC = 3;
   logic clock, reset, hsel, hwrite, pwr, stby, slot, at_tgt, pdn_otp;
   logic rd_dp, hreadyout, hresp, track, irq_n;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0]  htrans, g14, g34, g56, m;
   logic [5:0]  seq_en, ch_en, dvs, pdn;
   logic [47:0] otp, vcode;
   logic [11:0] ind, ch_mode, ilim, ind_out;
   logic [17:0] phase, leader;
   logic [7:0]  c;
   logic [63:0] note;
   logic [63:0] notes[$];
   int failures, total_checks, n;
   bcc_top #(.OFF_CYCLES(OFFC)) i_dut (
      .CLOCK(clock), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .POWER_UP(pwr), .STANDBY(stby), .SEQ_EN(seq_en),
      .SAME_SLOT(slot), .CH6_AT_TARGET(at_tgt), .OTP_VOLTAGE_CODE(otp),
      .INDUCTOR_VALUE_SEL(ind), .CH1_TO_4_GROUPING(g14),
      .CH3_4_GROUPING(g34), .CH5_6_GROUPING(g56),
      .TERMINATION_OFF_PULLDOWN(pdn_otp), .CH6_BOOT_SETPOINT(8'h40),
      .CH_ENABLE(ch_en), .CH_MODE(ch_mode), .CH_VOLTAGE_CODE(vcode),
      .CURRENT_LIMIT_SEL(ilim), .PHASE_SHIFT_SEL(phase),
      .INDUCTOR_OUT(ind_out), .CH_DVS_EN(dvs), .CH_PULLDOWN(pdn),
      .CH_LEADER(leader), .TRACK_CH5(track), .IRQ_OUT_N(irq_n));
   task automatic fail(input string s);
      failures++;
      $display("unexpected at %0t: %s", $time, s);
   endtask
   task automatic check_out(input logic [31:0] got, exp, input string s);
      total_checks++;
      if (got !== exp) fail(s);
   endtask
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_dp <= !wr;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, exp, mask);
      notes.push_back({mask, exp});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic pulse;
      @(posedge clock);
      pwr <= 1'b1;
      @(posedge clock);
      pwr <= 1'b0;
      repeat (3) tick;
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // The monitor pairs each read data phase with the oldest expectation.
   always @(posedge clock) begin
      if (rd_dp) begin
         note = notes.pop_front();
         check_out(hrdata & note[63:32], note[31:0], "read data");
      end
   end
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #50_000;
      fail("timeout");
      complete_run();
   end
   initial begin
      {reset, hsel, hwrite, pwr, stby, slot, at_tgt, rd_dp} = 8'h80;
      {haddr, hwdata, htrans, g14, g34, g56, seq_en, otp, ind} = '0;
      pdn_otp = 1'b1;
      void'($urandom(32'h967d_b7cb));
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      seq_en <= 6'($urandom());
      otp <= {$urandom(), 16'($urandom())};
      pdn_otp <= 1'($urandom());
      pulse();
      for (n = 0; n < 6; n++) begin
         m = seq_en[n] ? MODE_AUTO : MODE_OFF;
         c = otp[8*n +: 8];
         rd(REG_CH_BASE + 4 * n, {c, c, 7'h0, PHASE_0DEG, ILIM_2A1, m, m}, '1);
         check_out(32'(ch_mode[2*n +: 2]), 32'(m), "mode out");
      end
      bus(1'b1, REG_STATUS, 32'h0000_003f);
      repeat (3) tick;
      check_out(32'(irq_n), 32'h1, "irq idle");
      v = {16'h8080, 7'h0, 3'($urandom()), 2'($urandom()), MODE_PWM, MODE_PFM};
      bus(1'b1, REG_CH_BASE + 32'h4, v);
      for (n = 0; n < 10 && irq_n !== 1'b0; n++) tick;
      check_out(32'(irq_n), 32'h0, "irq on change");
      check_out(32'(ilim[3:2]), 32'(v[5:4]), "ilim");
      check_out(32'(phase[5:3]), 32'(v[8:6]), "phase");
      rd(REG_STATUS, 32'h2, 32'h3f);
      stby <= 1'b1;
      repeat (3) tick;
      check_out(32'(ch_mode[3:2]), 32'(MODE_PWM), "standby mode");
      stby <= 1'b0;
      bus(1'b1, REG_CTRL, 32'h2);
      repeat (3) tick;
      check_out(32'(irq_n), 32'h1, "irq masked");
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, REG_CH_BASE + 8, {16'h8080, 7'h0, PHASE_0DEG, 4'h0, 2'(k)});
         repeat (3) tick;
         check_out(32'(ch_mode[5:4]), k, "mode code");
         rd(REG_CH_BASE + 8, k, 32'h3);
      end
      bus(1'b1, REG_CH_BASE, {8'h80, VCODE_LOW_MAX, 7'h0, PHASE_0DEG, 4'h0, MODE_PWM});
      for (n = 0; n < 30 && vcode[7:0] !== VCODE_LOW_MAX; n++) tick;
      repeat (OFFC + 3) tick;
      bus(1'b1, REG_CH_BASE, {8'h80, VCODE_HIGH, 7'h0, PHASE_0DEG, 4'h0, MODE_PWM});
      for (n = 0; n < 10 && ch_en[0] !== 1'b0; n++) tick;
      for (n = 0; n < 20 && ch_en[0] === 1'b0; n++) tick;
      check_out(n, OFFC, "auto off span");
      check_out(32'(vcode[7:0]), 32'(VCODE_HIGH), "high code");
      bus(1'b1, REG_CH_BASE, {8'h80, 8'hB2, 7'h0, PHASE_0DEG, 4'h0, MODE_PWM});
      repeat (4) tick;
      check_out(32'(vcode[7:0]), 32'(VCODE_HIGH), "reserved code");
      slot <= 1'b1;
      seq_en <= 6'h3f;
      pulse();
      bus(1'b1, REG_CH_BASE + 32'h10,
          {16'h8080, 7'h0, PHASE_0DEG, 4'h0, MODE_AUTO});
      bus(1'b1, REG_CTRL, 32'h1);
      repeat (3) tick;
      check_out(32'(track), 32'h1, "same slot track");
      rd(REG_STATUS, 32'h0001_0000, 32'h0001_0000);
      bus(1'b1, REG_CH_BASE + 32'h14,
          {16'h2020, 7'h0, PHASE_0DEG, 4'h0, MODE_OFF});
      repeat (4) tick;
      check_out(32'(pdn[5]), 32'(pdn_otp), "ch6 off pulldown");
      bus(1'b1, REG_CH_BASE + 32'h14,
          {16'h2020, 7'h0, PHASE_0DEG, 4'h0, MODE_PWM});
      repeat (4) tick;
      check_out(32'(track), 32'h0, "ramp before track");
      at_tgt <= 1'b1;
      repeat (4) tick;
      check_out(32'(track), 32'h1, "track after ramp");
      // The second power-up reloaded every channel, so set ch1 and ch2 again.
      bus(1'b1, REG_CH_BASE, {16'h8080, 7'h0, PHASE_0DEG, 4'h0, MODE_PWM});
      bus(1'b1, REG_CH_BASE + 32'h4, v);
      for (int k = 0; k < 16; k++) begin
         g14 <= 2'(k);
         g34 <= 2'(k >> 2);
         g56 <= 2'($urandom());
         ind <= 12'($urandom());
         repeat (3) tick;
         m = (g14 != 2'h0) ? MODE_PWM : MODE_PFM;
         check_out(32'(ch_mode[3:2]), 32'(m), "group mode");
         check_out(32'(phase[5:3]), 32'(v[8:6]), "own phase");
      end
      rd(32'h0000_0040, 32'h0, '1);
      repeat (2) tick;
      complete_run();
   end
endmodule
